// *** sgd_defines.svh ***
/*
 Constants for the smart gate drive sequencer: register offsets, field
 positions, reset values and timing counts.
 Assumes a 20 MHz system clock and a 32-bit classic Wishbone slave.
*/
// Overview of operation
// R1 - Four-bit code selects one of sixteen rising currents
// R2 - Separate source and sink codes per driver
// R3 - Peak current during drive phase, then hold
// R4 - Turn on only after opposite gate off
// R5 - Optional programmable digital dead time added
// R6 - Strong pulldown while opposite switch transitions
// R7 - Sample gate monitor at drive end, flag fault
// R8 - New command aborts running drive phase timer
// R9 - Software sets drive phase above gate charge
// R10 - Gain from register or strap, divider from register or tied low
// R11 - Blanking and hold only on register variants
// R12 - Blanking triggered by selected half-bridge
// R13 - Blank output for period after gate transition
// R14 - Sample and hold opens switch on braking
// R15 - Reconnect output when braking state ends
// R16 - Drive phase duration from per-bridge field
// R17 - Dead time from per-bridge field
// R18 - Off gate held with strong pulldown
// R19 - Intervals counted by reloading tick counters
`ifndef SGD_DEFINES_SVH
`define SGD_DEFINES_SVH

`define SGD_ADDR_CTRL     8'h00
`define SGD_ADDR_IDRV     8'h04
`define SGD_ADDR_TIME     8'h08
`define SGD_ADDR_CSA      8'h0C
`define SGD_ADDR_STATUS   8'h10
`define SGD_ADDR_MASK     8'h14
`define SGD_ADDR_GATE     8'h18

`define SGD_CTRL_RESET    32'h0000_0000
`define SGD_IDRV_RESET    32'h0000_0000
`define SGD_TIME_RESET    32'h0000_0000
`define SGD_CSA_RESET     32'h0000_0000

`define SGD_AMP_GAIN_SEL_LSB  0
`define SGD_REF_DIVIDER_SEL_BIT   2
`define SGD_CSA_BLKSEL    3
`define SGD_CSA_BLKEN     4
`define SGD_CSA_SHEN      5
`define SGD_BLANK_PERIOD_SEL_LSB   8

`define SGD_CLK_HZ        20000000
`define SGD_TICK_NS       250
`define SGD_TICK_CYC      ((`SGD_TICK_NS * (`SGD_CLK_HZ / 1000000)) / 1000)

`endif

// *** sgd_pkg.sv ***
/*
 Types for the smart gate drive sequencer.
 Assumes the defines header is included by users needing constants.
*/
package sgd_pkg;
    typedef enum logic [2:0] {
        SGD_OFF,
        SGD_WAIT_OPP,
        SGD_DEAD,
        SGD_DRIVE_ON,
        SGD_HOLD_ON,
        SGD_DRIVE_OFF
    } sgd_state_e;
    typedef logic [3:0] sgd_code_t;
endpackage

// *** sgd_switch.sv ***
/*
 One gate driver channel: dead-time handshake, drive phase timing and
 gate fault check. Assumes a synchronised command and gate monitors.
*/
`timescale 1ns/1ps
`include "sgd_defines.svh"
module sgd_switch
    import sgd_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       tick_i,
    input  wire logic       cmd_i,
    input  wire logic       opp_off_i,
    input  wire logic       gate_on_i,
    input  wire logic [7:0] tdrv_i,
    input  wire logic [7:0] deadtime_interval_i,
    output logic            gate_o,
    output logic            peak_o,
    output logic            busy_o,
    output logic            fault_o
);
    typedef struct packed {
        sgd_state_e st;
        logic [7:0] cnt;
        logic       gate;
        logic       peak;
        logic       fault;
        logic       cmd_d;
    } sgd_sw_s;

    sgd_sw_s q;
    sgd_sw_s next_q;

    always_comb begin
        next_q       = q;
        next_q.fault = 1'b0;
        next_q.cmd_d = cmd_i;
        if (tick_i && q.cnt != 8'h00) begin
            next_q.cnt = q.cnt - 8'h01; // R19
        end
        if (cmd_i != q.cmd_d) begin
            next_q.cnt = tdrv_i; // R8 R16 R19
            if (cmd_i) begin
                next_q.st   = SGD_WAIT_OPP;
                next_q.gate = 1'b0;
                next_q.peak = 1'b0;
            end else begin
                next_q.st   = SGD_DRIVE_OFF;
                next_q.gate = 1'b0;
                next_q.peak = 1'b1;
            end
        end else begin
            case (q.st)
                SGD_OFF: begin
                    next_q.peak = 1'b0; // R18
                end
                SGD_WAIT_OPP: begin
                    if (opp_off_i) begin // R4
                        next_q.st  = SGD_DEAD;
                        next_q.cnt = deadtime_interval_i; // R5 R17
                    end
                end
                SGD_DEAD: begin
                    if (q.cnt == 8'h00) begin
                        next_q.st   = SGD_DRIVE_ON;
                        next_q.gate = 1'b1;
                        next_q.peak = 1'b1; // R3
                        next_q.cnt  = tdrv_i; // R16
                    end
                end
                SGD_DRIVE_ON: begin
                    if (q.cnt == 8'h00) begin
                        next_q.st    = SGD_HOLD_ON;
                        next_q.peak  = 1'b0; // R3
                        next_q.fault = !gate_on_i; // R7
                    end
                end
                SGD_HOLD_ON: begin
                    next_q.peak = 1'b0;
                end
                SGD_DRIVE_OFF: begin
                    if (q.cnt == 8'h00) begin
                        next_q.st    = SGD_OFF;
                        next_q.peak  = 1'b0; // R18
                        next_q.fault = gate_on_i; // R7
                    end
                end
                default: begin
                    next_q.st = SGD_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{st: SGD_OFF, cnt: 8'h00, gate: 1'b0, peak: 1'b0,
                   fault: 1'b0, cmd_d: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign gate_o  = q.gate;
    assign peak_o  = q.peak;
    assign fault_o = q.fault;
    assign busy_o  = q.peak || q.st == SGD_WAIT_OPP || q.st == SGD_DEAD;
endmodule

// *** sgd_top.sv ***
/*
 Smart gate drive sequencer top: Wishbone registers, two half-bridges of
 gate channels, current code selection, amplifier output switch control
 and a fault interrupt. Assumes commands and gate monitors are pins.
*/
`timescale 1ns/1ps
`include "sgd_defines.svh"
module sgd_top
    import sgd_pkg::*;
#(
    parameter int NUM_BRIDGE = 2
)(
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    cyc_i,
    input  wire logic                    stb_i,
    input  wire logic                    we_i,
    input  wire logic [7:0]              adr_i,
    input  wire logic [3:0]              sel_i,
    input  wire logic [31:0]             dat_i,
    output logic [31:0]                  dat_o,
    output logic                         ack_o,
    input  wire logic                    hw_variant_i,
    input  wire logic [3:0]              drive_strength_strap_i,
    input  wire logic [1:0]              gain_strap_i,
    input  wire logic [NUM_BRIDGE-1:0]   hs_cmd_i,
    input  wire logic [NUM_BRIDGE-1:0]   ls_cmd_i,
    input  wire logic [NUM_BRIDGE-1:0]   hs_vgs_on_i,
    input  wire logic [NUM_BRIDGE-1:0]   ls_vgs_on_i,
    output logic [NUM_BRIDGE-1:0]        high_side_gate_out_o,
    output logic [NUM_BRIDGE-1:0]        low_side_gate_out_o,
    output logic [NUM_BRIDGE-1:0]        hs_strong_pd_o,
    output logic [NUM_BRIDGE-1:0]        ls_strong_pd_o,
    output logic [NUM_BRIDGE-1:0]        hs_peak_o,
    output logic [NUM_BRIDGE-1:0]        ls_peak_o,
    output logic [NUM_BRIDGE*4-1:0]      hs_current_code_o,
    output logic [NUM_BRIDGE*4-1:0]      ls_current_code_o,
    output logic [1:0]                   amp_gain_sel_o,
    output logic                         ref_divider_sel_o,
    output logic                         amp_out_connect_o,
    output logic                         irq_o
);
    localparam int NCH = 2 * NUM_BRIDGE;

    typedef struct packed {
        logic [31:0]            ctrl;
        logic [31:0]            idrv;
        logic [31:0]            time_cfg;
        logic [31:0]            csa;
        logic [NCH-1:0]         status;
        logic [NCH-1:0]         mask;
        logic                   ack;
        logic [31:0]            rdata;
        logic [7:0]             tick_cnt;
        logic                   tick;
        logic [7:0]             blank_cnt;
        logic [2*NUM_BRIDGE-1:0] gate_d;
        logic [4*NUM_BRIDGE-1:0] sync1;
        logic [4*NUM_BRIDGE-1:0] sync2;
        logic [3:0]             strap1;
        logic [3:0]             strap2;
        logic                   hw1;
        logic                   hw2;
        logic [1:0]             gain1;
        logic [1:0]             gain2;
    } sgd_top_s;

    sgd_top_s q;
    sgd_top_s next_q;

    ////////////////////////////////////////////////////////////////////////
    logic [NCH-1:0] cmd_s;
    logic [NCH-1:0] mon_s;
    logic [NCH-1:0] gate_w;
    logic [NCH-1:0] peak_w;
    logic [NCH-1:0] busy_w;
    logic [NCH-1:0] fault_w;
    logic           wr;
    logic [31:0]    wmask;

    assign cmd_s = q.sync2[2*NUM_BRIDGE-1:0];
    assign mon_s = q.sync2[4*NUM_BRIDGE-1:2*NUM_BRIDGE];
    assign wr    = cyc_i && stb_i && we_i && !q.ack;
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}},
                    {8{sel_i[1]}}, {8{sel_i[0]}}};

    ////////////////////////////////////////////////////////////////////////
    // Channel c: even = high side, odd = low side of bridge c/2
    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            sgd_switch u_sw (
                .clk_i     (clk_i),
                .rst_i     (rst_i),
                .tick_i    (q.tick),
                .cmd_i     (cmd_s[c]),
                .opp_off_i (!mon_s[c ^ 1] && !gate_w[c ^ 1]), // R4
                .gate_on_i (mon_s[c]),
                .tdrv_i    (q.time_cfg[(c/2)*8 +: 8]),
                .deadtime_interval_i   (q.time_cfg[16 + (c/2)*8 +: 8]),
                .gate_o    (gate_w[c]),
                .peak_o    (peak_w[c]),
                .busy_o    (busy_w[c]),
                .fault_o   (fault_w[c])
            );
        end
        for (c = 0; c < NUM_BRIDGE; c++) begin : g_br
            assign high_side_gate_out_o[c] = gate_w[2*c];
            assign low_side_gate_out_o[c]  = gate_w[2*c+1];
            assign hs_peak_o[c]            = peak_w[2*c];
            assign ls_peak_o[c]            = peak_w[2*c+1];
            // Off gate held strong, also while partner slews
            assign hs_strong_pd_o[c] = !gate_w[2*c] &&
                (!peak_w[2*c] || busy_w[2*c+1]); // R6 R18
            assign ls_strong_pd_o[c] = !gate_w[2*c+1] &&
                (!peak_w[2*c+1] || busy_w[2*c]); // R6 R18
            // Strap code on the hardwired variant; otherwise source code while on, sink code while off
            assign hs_current_code_o[c*4 +: 4] = q.hw2 ?
                q.strap2 : (gate_w[2*c] ? q.idrv[c*16 +: 4]
                : q.idrv[c*16+4 +: 4]); // R1 R2
            assign ls_current_code_o[c*4 +: 4] = q.hw2 ?
                q.strap2 : (gate_w[2*c+1] ? q.idrv[c*16+8 +: 4]
                : q.idrv[c*16+12 +: 4]); // R1 R2
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    logic       blk_sel;
    logic       trans;
    logic       braking;
    logic [1:0] bgates;

    assign blk_sel = q.csa[`SGD_CSA_BLKSEL];
    assign bgates  = blk_sel ? gate_w[3:2] : gate_w[1:0]; // R12
    assign trans   = bgates != (blk_sel ? q.gate_d[3:2] : q.gate_d[1:0]);
    assign braking = (gate_w[0] && gate_w[2]) ||
                     (gate_w[1] && gate_w[3]); // R14

    always_comb begin
        next_q        = q;
        next_q.ack    = cyc_i && stb_i && !q.ack;
        // Commands low half, monitors high half; even bit high side
        for (int b = 0; b < NUM_BRIDGE; b++) begin
            next_q.sync1[2*b]                = hs_cmd_i[b];
            next_q.sync1[2*b+1]              = ls_cmd_i[b];
            next_q.sync1[2*NUM_BRIDGE+2*b]   = hs_vgs_on_i[b];
            next_q.sync1[2*NUM_BRIDGE+2*b+1] = ls_vgs_on_i[b];
        end
        next_q.sync2  = q.sync1;
        next_q.strap1 = drive_strength_strap_i;
        next_q.strap2 = q.strap1;
        next_q.hw1    = hw_variant_i;
        next_q.hw2    = q.hw1;
        next_q.gain1  = gain_strap_i;
        next_q.gain2  = q.gain1;
        next_q.gate_d = gate_w;
        next_q.tick   = 1'b0;
        if (q.tick_cnt == 8'(`SGD_TICK_CYC - 1)) begin
            next_q.tick_cnt = 8'h00;
            next_q.tick     = 1'b1;
        end else begin
            next_q.tick_cnt = q.tick_cnt + 8'h01;
        end
        if (trans && q.csa[`SGD_CSA_BLKEN]) begin
            next_q.blank_cnt = q.csa[`SGD_BLANK_PERIOD_SEL_LSB +: 8]; // R13 R19
        end else if (q.tick && q.blank_cnt != 8'h00) begin
            next_q.blank_cnt = q.blank_cnt - 8'h01;
        end
        if (wr) begin
            case (adr_i)
                `SGD_ADDR_CTRL:
                    next_q.ctrl = (q.ctrl & ~wmask) | (dat_i & wmask);
                `SGD_ADDR_IDRV:
                    next_q.idrv = (q.idrv & ~wmask) | (dat_i & wmask);
                `SGD_ADDR_TIME:
                    next_q.time_cfg = (q.time_cfg & ~wmask)
                                    | (dat_i & wmask);
                `SGD_ADDR_CSA:
                    next_q.csa = (q.csa & ~wmask) | (dat_i & wmask);
                `SGD_ADDR_STATUS:
                    next_q.status = q.status & ~(dat_i[NCH-1:0]
                                  & wmask[NCH-1:0]);
                `SGD_ADDR_MASK:
                    next_q.mask = (q.mask & ~wmask[NCH-1:0])
                                | (dat_i[NCH-1:0] & wmask[NCH-1:0]);
                default: begin
                end
            endcase
        end
        next_q.status = next_q.status | fault_w; // R7
        case (adr_i)
            `SGD_ADDR_CTRL:   next_q.rdata = q.ctrl;
            `SGD_ADDR_IDRV:   next_q.rdata = q.idrv;
            `SGD_ADDR_TIME:   next_q.rdata = q.time_cfg;
            `SGD_ADDR_CSA:    next_q.rdata = q.csa;
            `SGD_ADDR_STATUS: next_q.rdata = 32'(q.status);
            `SGD_ADDR_MASK:   next_q.rdata = 32'(q.mask);
            `SGD_ADDR_GATE:   next_q.rdata = 32'({busy_w, gate_w});
            default:          next_q.rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q          <= '0;
            q.ctrl     <= `SGD_CTRL_RESET;
            q.idrv     <= `SGD_IDRV_RESET;
            q.time_cfg <= `SGD_TIME_RESET;
            q.csa      <= `SGD_CSA_RESET;
        end else begin
            q <= next_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign dat_o  = q.rdata;
    assign ack_o  = q.ack;
    assign irq_o  = |(q.status & q.mask);
    assign amp_gain_sel_o    = q.hw2 ? q.gain2
                             : q.csa[`SGD_AMP_GAIN_SEL_LSB +: 2]; // R10
    assign ref_divider_sel_o = q.hw2 ? 1'b0
                             : q.csa[`SGD_REF_DIVIDER_SEL_BIT]; // R10
    assign amp_out_connect_o = q.hw2 ||
        !((q.blank_cnt != 8'h00) ||
          (q.csa[`SGD_CSA_SHEN] && braking)); // R11 R13 R14 R15
endmodule

// *** sgd_fet_model.sv ***
/*
 Gate model of four external power switches in two half-bridges.
 Assumes the gate monitor reads on DLY clocks after the drive rises.
*/
`timescale 1ns/1ps
module sgd_fet_model #(
    parameter int DLY = 3
)(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] gate_i,
    input  wire logic [3:0] stuck_i,
    output logic [3:0]      vgs_o
);
    logic [3:0] pipe [DLY];
    // Gate charge takes DLY clocks; a stuck gate never reaches on
    always_ff @(posedge clk_i) begin
        pipe[0] <= rst_i ? 4'h0 : gate_i;
        for (int i = 1; i < DLY; i++) pipe[i] <= rst_i ? 4'h0 : pipe[i-1];
    end
    assign vgs_o = pipe[DLY-1] & ~stuck_i;
endmodule

// *** sgd_top_properties.sv ***
/*
 Port checker for the gate drive sequencer top.
 Assumes it is bound to every sgd_top instance.
*/
`timescale 1ns/1ps
module sgd_top_properties #(
    parameter int NUM_BRIDGE = 2
)(
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    input wire logic                  cyc_i,
    input wire logic                  stb_i,
    input wire logic                  ack_o,
    input wire logic                  hw_variant_i,
    input wire logic [1:0]            gain_strap_i,
    input wire logic [NUM_BRIDGE-1:0] hs_vgs_on_i,
    input wire logic [NUM_BRIDGE-1:0] ls_vgs_on_i,
    input wire logic [NUM_BRIDGE-1:0] high_side_gate_out_o,
    input wire logic [NUM_BRIDGE-1:0] low_side_gate_out_o,
    input wire logic [NUM_BRIDGE-1:0] hs_strong_pd_o,
    input wire logic [NUM_BRIDGE-1:0] hs_peak_o,
    input wire logic [1:0]            amp_gain_sel_o,
    input wire logic                  ref_divider_sel_o,
    input wire logic                  amp_out_connect_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_next: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack after request");
    chk_ack_once: assert property (
        ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_no_shoot: assert property (
        (high_side_gate_out_o & low_side_gate_out_o) == '0)
        else $error("both gates of a bridge on");
    chk_hs_wait: assert property (
        $rose(high_side_gate_out_o[0]) |->
        !low_side_gate_out_o[0] && !$past(ls_vgs_on_i[0], 2))
        else $error("high side on before low side off");
    chk_ls_wait: assert property (
        $rose(low_side_gate_out_o[0]) |->
        !high_side_gate_out_o[0] && !$past(hs_vgs_on_i[0], 2))
        else $error("low side on before high side off");
    chk_pd_idle: assert property (
        !high_side_gate_out_o[0] && !hs_peak_o[0] |-> hs_strong_pd_o[0])
        else $error("idle off gate without strong pulldown");
    chk_hw_gain: assert property (
        $past(hw_variant_i, 2) |-> amp_gain_sel_o == $past(gain_strap_i, 2))
        else $error("gain not taken from strap");
    chk_hw_output: assert property (
        hw_variant_i && $past(hw_variant_i, 3) |->
        amp_out_connect_o && !ref_divider_sel_o)
        else $error("hardwired amp output or divider wrong");
endmodule

bind sgd_top sgd_top_properties #(.NUM_BRIDGE(NUM_BRIDGE)) u_chk (
    .clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .hw_variant_i, .gain_strap_i,
    .hs_vgs_on_i, .ls_vgs_on_i, .high_side_gate_out_o,
    .low_side_gate_out_o, .hs_strong_pd_o, .hs_peak_o, .amp_gain_sel_o,
    .ref_divider_sel_o, .amp_out_connect_o);

// *** sgd_top_test.sv ***
/*
 Self-checking bench for the gate drive sequencer top.
 Assumes a Wishbone slave acking one cycle after each request.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    num_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); \
    end end
`define WAITC(c) begin n = 0; while (!(c) && n < 300) begin \
    @(posedge clk_i); n++; end if (!(c)) num_errors++; end
module sgd_top_test;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic        ack_o, hw = 0, irq_o, div_o, conn_o;
    logic [7:0]  adr_i = 0, code_hs, code_ls;
    logic [3:0]  sel_i = 4'hF, strap = 0, stuck = 0, vgs;
    logic [31:0] dat_i = 0, dat_o, r;
    logic [1:0]  gain = 0, hs_cmd = 0, ls_cmd = 0, hs_g, ls_g, gsel;
    logic [1:0]  pd_hs, pd_ls, pk_hs, pk_ls;
    int          num_errors = 0, samples_checked = 0, n, k;
    logic [7:0]  ra [6] = '{8'h04, 8'h08, 8'h0C, 8'h14, 8'h1C, 8'h18};
    logic [31:0] rx [6] = '{32'h5A3C_96E1, 32'h5A3C_96E1, 32'h5A3C_96E1,
                            32'h0000_0001, 32'h0, 32'h0};

    sgd_top i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .hw_variant_i(hw),
        .drive_strength_strap_i(strap), .gain_strap_i(gain),
        .hs_cmd_i(hs_cmd), .ls_cmd_i(ls_cmd),
        .hs_vgs_on_i({vgs[2], vgs[0]}), .ls_vgs_on_i({vgs[3], vgs[1]}),
        .high_side_gate_out_o(hs_g), .low_side_gate_out_o(ls_g),
        .hs_strong_pd_o(pd_hs), .ls_strong_pd_o(pd_ls), .hs_peak_o(pk_hs),
        .ls_peak_o(pk_ls), .hs_current_code_o(code_hs),
        .ls_current_code_o(code_ls), .amp_gain_sel_o(gsel),
        .ref_divider_sel_o(div_o), .amp_out_connect_o(conn_o), .irq_o);
    sgd_fet_model i_fet (.clk_i, .rst_i, .stuck_i(stuck), .vgs_o(vgs),
        .gate_i({ls_g[1], hs_g[1], ls_g[0], hs_g[0]}));

    always #25 clk_i = ~clk_i;

    task automatic tally_and_finish;
        if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int t;
        t = 0;
        @(posedge clk_i);
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d;
        do begin @(posedge clk_i); t++; end while (ack_o !== 1'b1 && t < 50);
        if (ack_o !== 1'b1) num_errors++;
        q = dat_o;
        cyc_i <= 0; stb_i <= 0; we_i <= 0;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        for (int i = 0; i < 6; i++) begin
            wb(0, ra[i], 0, r);
            `CHK(r, 32'h0)
            wb(1, ra[i], 32'h5A3C_96E1, r);
            wb(0, ra[i], 0, r);
            `CHK(r, rx[i])
        end
        sel_i <= 4'h1;
        wb(1, 8'h04, 0, r);
        sel_i <= 4'hF;
        wb(0, 8'h04, 0, r);
        `CHK(r, 32'h5A3C_9600)
        wb(1, 8'h04, 32'h0000_A5C3, r);
        wb(1, 8'h08, 32'h0101_0404, r);
        wb(1, 8'h0C, 32'h0000_0007, r);
        wb(1, 8'h14, 32'h0, r);
        `CHK({gsel, div_o}, 3'h7)
        `CHK({code_hs[3:0], code_ls[3:0]}, 8'hCA)
        hs_cmd[0] <= 1;
        `WAITC(hs_g[0])
        `CHK({pk_hs[0], code_hs[3:0]}, 5'h13)
        `WAITC(!pk_hs[0])
        `CHK(n inside {[14:22]}, 1'b1)
        `CHK(hs_g[0], 1'b1)
        hs_cmd[0] <= 0;
        ls_cmd[0] <= 1;
        `WAITC(ls_g[0])
        `CHK({pk_hs[0], pd_hs[0]}, 2'b11)
        `CHK(vgs[0], 1'b0)
        `CHK(n >= 8, 1'b1)
        `WAITC(!pk_ls[0])
        wb(0, 8'h10, 0, r);
        `CHK(r, 32'h0)
        ls_cmd[0] <= 0;
        hs_cmd[0] <= 1;
        `WAITC(hs_g[0])
        hs_cmd[0] <= 0;
        `WAITC(!hs_g[0])
        `CHK(n <= 4, 1'b1)
        repeat (2) @(posedge clk_i);
        `WAITC(!pk_hs[0])
        wb(0, 8'h10, 0, r);
        `CHK(r, 32'h0)
        stuck[0] <= 1;
        hs_cmd[0] <= 1;
        `WAITC(hs_g[0])
        `WAITC(!pk_hs[0])
        wb(0, 8'h10, 0, r);
        `CHK({r, irq_o}, 33'h2)
        wb(1, 8'h14, 32'h1, r);
        @(posedge clk_i);
        `CHK(irq_o, 1'b1)
        wb(1, 8'h10, 32'h1, r);
        @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        stuck[0] <= 0;
        hs_cmd[0] <= 0;
        repeat (2) @(posedge clk_i);
        `WAITC(!pk_hs[0])
        wb(1, 8'h0C, 32'h0000_0020, r);
        ls_cmd <= 2'b11;
        `WAITC(ls_g == 2'b11)
        repeat (3) @(posedge clk_i);
        `CHK(conn_o, 1'b0)
        ls_cmd <= 2'b01;
        `WAITC(conn_o)
        `CHK(n < 8, 1'b1)
        wb(1, 8'h0C, 32'h0000_0210, r);
        hs_cmd[1] <= 1;
        k = 0;
        repeat (20) begin
            @(posedge clk_i);
            if (conn_o !== 1'b1) k++;
        end
        `CHK(k, 0)
        ls_cmd[0] <= 0;
        `WAITC(!conn_o)
        `CHK(n < 8, 1'b1)
        `WAITC(conn_o)
        `CHK(n inside {[4:12]}, 1'b1)
        hw <= 1;
        gain <= 2'h2;
        strap <= 4'hF;
        repeat (4) @(posedge clk_i);
        `CHK({gsel, div_o, conn_o}, 4'h9)
        `CHK({code_hs, code_ls}, 16'hFFFF)
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        `CHK({hs_g, ls_g, pd_hs, pd_ls}, 8'h0F)
        rst_i <= 0;
        tally_and_finish();
    end
endmodule
